// >>> include/als_defines.svh
// constants of the dual channel light sensor readout
// assumes a 100 MHz hclk and a 32-bit ahb-lite register bus
`ifndef ALS_DEFINES_SVH
`define ALS_DEFINES_SVH
// register byte offsets (haddr[7:0])
`define ALS_CTRL        8'h00
`define ALS_TIMING      8'h04
`define ALS_THR_LO      8'h08
`define ALS_THR_HI      8'h0c
`define ALS_PERS        8'h10
`define ALS_DATA        8'h14
`define ALS_STATUS      8'h18
`define ALS_MASK        8'h1c
`define ALS_INTCLR      8'h20
// ctrl fields
`define ALS_CTRL_EN     0
`define ALS_CTRL_INTEN  1
`define ALS_CTRL_ALERT  2
`define ALS_CTRL_GAIN   4
// status and mask fields
`define ALS_ST_DONE     0
`define ALS_ST_THR      1
// reset values
`define ALS_CTRL_RST    8'h03
`define ALS_TIMING_RST  8'h25
`define ALS_THR_LO_RST  16'h0000
`define ALS_THR_HI_RST  16'hffff
`define ALS_PERS_RST    4'h1
// timing: one integration cycle is 2.7 ms (750 kHz oscillator)
`define ALS_CLK_NS      10
`define ALS_OSC_KHZ     750
`define ALS_ICYC_NS     2700000
`define ALS_ICYC_CLKS   (`ALS_ICYC_NS / `ALS_CLK_NS)
// serial link addresses (own address arbitrary)
`define ALS_I2C_ADDR    7'h2a
`define ALS_ARA_ADDR    7'h0c
`endif

// >>> include/als_pkg.sv
// types of the dual channel light sensor readout
// assumes nothing beyond a systemverilog compiler
package als_pkg;
   typedef enum logic [6:0] {
      I2C_IDLE = 7'h01,
      I2C_ADDR = 7'h02,
      I2C_ACKA = 7'h04,
      I2C_WR   = 7'h08,
      I2C_ACKW = 7'h10,
      I2C_RD   = 7'h20,
      I2C_ACKR = 7'h40
   } als_i2c_fsm_t;

   typedef struct packed {
      als_i2c_fsm_t st;
      logic [3:0]   bitcnt;
      logic [7:0]   sh;
      logic         rw;
      logic         ara;
      logic [1:0]   ptr;
      logic [31:0]  snap;
      logic         scl_p;
      logic         sda_p;
      logic         oe_n;
   } als_i2c_st_t;

   typedef struct packed {
      logic        scl_m, scl_s, sda_m, sda_s;
      logic        p0_m, p0_s, p0_p, p1_m, p1_s, p1_p;
      logic        en, inten, alert;
      logic [1:0]  gain;
      logic [7:0]  icnt;
      logic [15:0] thr_lo, thr_hi;
      logic [3:0]  pers, oor;
      logic [18:0] tick;
      logic [7:0]  cyc;
      logic [15:0] acc0, acc1, res0, res1;
      logic [1:0]  stat, mask;
      logic        int_act;
      logic        a_wr;
      logic [7:0]  a_addr;
      logic [31:0] hrdata;
   } als_top_st_t;
endpackage

// >>> core/als_i2c_slave.sv
// serial link slave: address match, pointer write, result reads, alert response
// assumes scl and sda already pass two flip-flops on hclk
`timescale 1ns/1ps
`default_nettype none
`include "als_defines.svh"
module als_i2c_slave import als_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        scl_s,
   input  wire logic        sda_s,
   input  wire logic [31:0] rd_data,
   input  wire logic        alert_act,
   output logic             sda_oe_n,
   output logic             ara_done
);
   als_i2c_st_t q;
   als_i2c_st_t n;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic [7:0]  tx;

   // byte p of the snapshot word, low byte first
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] p);
      pick_byte = w[{p, 3'b000} +: 8];
   endfunction

   // link state machine on sampled scl edges
   always_comb begin
      n        = q;
      tx       = 8'h00;
      ara_done = 1'b0;
      n.scl_p  = scl_s;
      n.sda_p  = sda_s;
      scl_rise = scl_s & ~q.scl_p;
      scl_fall = ~scl_s & q.scl_p;
      start_c  = scl_s & q.scl_p & q.sda_p & ~sda_s;
      stop_c   = scl_s & q.scl_p & ~q.sda_p & sda_s;
      if (start_c) begin
         n.st     = I2C_ADDR;
         n.bitcnt = 4'h0;
         n.oe_n   = 1'b1;
      end else if (stop_c) begin
         n.st   = I2C_IDLE;
         n.oe_n = 1'b1;
      end else begin
         unique case (q.st)
            I2C_IDLE: n.oe_n = 1'b1;
            I2C_ADDR, I2C_WR: begin
               if (scl_rise) begin
                  n.sh     = {q.sh[6:0], sda_s};
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'h8) begin
                  if (q.st == I2C_WR) begin
                     n.ptr  = q.sh[1:0];
                     n.oe_n = 1'b0;
                     n.st   = I2C_ACKW;
                  end else if (q.sh[7:1] == `ALS_I2C_ADDR) begin
                     n.oe_n = 1'b0;
                     n.rw   = q.sh[0];
                     n.ara  = 1'b0;
                     n.snap = rd_data; // whole word frozen for the read
                     n.st   = I2C_ACKA;
                  end else if (q.sh[7:1] == `ALS_ARA_ADDR && q.sh[0] && alert_act) begin
                     n.oe_n = 1'b0;
                     n.rw   = 1'b1;
                     n.ara  = 1'b1;
                     n.ptr  = 2'h0;
                     n.snap = {24'h0, `ALS_I2C_ADDR, 1'b0}; // alert answer
                     n.st   = I2C_ACKA;
                  end else begin
                     n.st = I2C_IDLE;
                  end
               end
            end
            I2C_ACKW: if (scl_fall) begin
               n.oe_n   = 1'b1;
               n.bitcnt = 4'h0;
               n.st     = I2C_WR;
            end
            I2C_ACKA, I2C_ACKR: begin
               if (scl_rise && q.st == I2C_ACKR && sda_s) begin
                  n.st = I2C_IDLE; // master nack ends the read
               end else if (scl_fall && q.rw) begin
                  tx       = pick_byte(q.snap, q.ptr);
                  n.oe_n   = tx[7];
                  n.sh     = {tx[6:0], 1'b0};
                  n.bitcnt = 4'h1;
                  n.ptr    = q.ptr + 2'h1;
                  n.st     = I2C_RD;
                  ara_done = q.ara & (q.st == I2C_ACKA);
               end else if (scl_fall) begin
                  n.oe_n   = 1'b1;
                  n.bitcnt = 4'h0;
                  n.st     = I2C_WR;
               end
            end
            I2C_RD: if (scl_fall) begin
               if (q.bitcnt == 4'h8) begin
                  n.oe_n = 1'b1;
                  n.st   = I2C_ACKR;
               end else begin
                  n.oe_n   = q.sh[7];
                  n.sh     = {q.sh[6:0], 1'b0};
                  n.bitcnt = q.bitcnt + 4'h1;
               end
            end
            default: n.st = I2C_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q      <= '0;
         q.st   <= I2C_IDLE;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
         q.oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign sda_oe_n = q.oe_n;
endmodule
`default_nettype wire

// >>> core/als_readout.sv
// dual channel light sensor readout: converters, results, threshold alarm, registers
// assumes ahb-lite master on hclk, converter pulses and link pins from outside hclk
//
// Contract
// - both channels integrate over one shared window that starts and ends together.
// - at the end of a cycle channel 0 takes the broadband count, channel 1 the infrared.
// - results change as a whole, so no read sees a half old, half new value.
// - after the transfer the next integration starts by itself.
// - a channel 0 result above the upper or below the lower threshold raises the interrupt.
// - only a run of out-of-window results as long as the persistence setting (a setting of 0 counts as 1) raises it.
// - in level style the interrupt stays asserted until the host clears it.
// - in alert style the interrupt follows the smbus alert response convention.
// - the interrupt pin is open drain, pulled low when asserted, released otherwise.
// - each channel result is presented as a 16-bit value.
// - the link runs at most 100 kHz in smbus use and 400 kHz in i2c use.
// - the host programs the analog gain and the integration time.
// - integration time is the cycle count times a 2.7 ms integration cycle; a count of 0 runs one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "als_defines.svh"
module als_readout import als_pkg::*; #(
   parameter int unsigned INTEG_CYC_CLKS = `ALS_ICYC_CLKS
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irq,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n,
   input  wire logic        int_i,
   output logic             int_o,
   output logic             int_oe_n,
   input  wire logic        ch0_pulse_i,
   input  wire logic        ch1_pulse_i,
   output logic [1:0]       gain_o
);
   als_top_st_t q;
   als_top_st_t n;
   logic        e0;
   logic        e1;
   logic        conv_end;
   logic        out_win;
   logic        thr_hit;
   logic        clr_wr;
   logic        sel;
   logic        ara_done;
   logic [7:0]  cyc_last;
   logic [3:0]  pers_eff;
   logic [3:0]  oor_nx;
   localparam logic [7:0]  CTRL_RST  = `ALS_CTRL_RST;           // reset control word
   localparam logic [18:0] TICK_LAST = 19'(INTEG_CYC_CLKS - 1); // last tick of one cycle

   // one more converter count, held at full scale
   function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic e);
      sat_inc = (e && v != 16'hffff) ? v + 16'h1 : v;
   endfunction

   // result outside the programmed window
   function automatic logic outside(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
      outside = (v < lo) || (v > hi);
   endfunction

   // whole block state: syncs, converters, alarm, registers
   always_comb begin
      n        = q;
      conv_end = 1'b0;
      out_win  = 1'b0;
      thr_hit  = 1'b0;
      oor_nx   = q.oor;
      // two-flop pin synchronisers; link speed set by the host
      n.scl_m  = scl_i;
      n.scl_s  = q.scl_m;
      n.sda_m  = sda_i;
      n.sda_s  = q.sda_m;
      n.p0_m   = ch0_pulse_i;
      n.p0_s   = q.p0_m;
      n.p0_p   = q.p0_s;
      n.p1_m   = ch1_pulse_i;
      n.p1_s   = q.p1_m;
      n.p1_p   = q.p1_s;
      e0       = q.p0_s & ~q.p0_p;
      e1       = q.p1_s & ~q.p1_p;
      cyc_last = (q.icnt == 8'h00) ? 8'h00 : q.icnt - 8'h01;
      pers_eff = (q.pers == 4'h0) ? 4'h1 : q.pers;

      // shared integration window for both channels
      if (q.en) begin
         n.acc0 = sat_inc(q.acc0, e0); // 16-bit counts
         n.acc1 = sat_inc(q.acc1, e1);
         if (q.tick == TICK_LAST) begin
            n.tick = 19'h0;
            if (q.cyc >= cyc_last) begin // a shortened count ends the window at the end of the current cycle
               conv_end = 1'b1;
               n.cyc    = 8'h00;
            end else begin
               n.cyc = q.cyc + 8'h01;
            end
         end else begin
            n.tick = q.tick + 19'h1;
         end
      end else begin
         n.tick = 19'h0;
         n.cyc  = 8'h00;
         n.acc0 = 16'h0;
         n.acc1 = 16'h0;
      end

      // transfer both results at once, then restart
      if (conv_end) begin
         n.res0 = n.acc0;
         n.res1 = n.acc1;
         n.acc0 = 16'h0;
         n.acc1 = 16'h0;
      end

      // window test on channel 0 at the transfer
      if (conv_end) begin
         out_win = outside(n.res0, q.thr_lo, q.thr_hi);
         if (out_win) begin
            oor_nx = (q.oor == 4'hf) ? 4'hf : q.oor + 4'h1;
         end else begin
            oor_nx = 4'h0;
         end
         n.oor   = oor_nx;
         thr_hit = out_win && (oor_nx >= pers_eff);
      end

      // ahb-lite address phase: latch and answer reads
      sel      = hsel & hready & htrans[1];
      n.a_wr   = sel & hwrite & (hsize == 3'b010);
      n.a_addr = haddr[7:0];
      if (sel && !hwrite) begin
         unique case (haddr[7:0])
            `ALS_CTRL:   n.hrdata = {26'h0, q.gain, 1'b0, q.alert, q.inten, q.en};
            `ALS_TIMING: n.hrdata = {24'h0, q.icnt};
            `ALS_THR_LO: n.hrdata = {16'h0, q.thr_lo};
            `ALS_THR_HI: n.hrdata = {16'h0, q.thr_hi};
            `ALS_PERS:   n.hrdata = {28'h0, q.pers};
            `ALS_DATA:   n.hrdata = {q.res1, q.res0}; // one word, one snapshot
            `ALS_STATUS: n.hrdata = {30'h0, q.stat};
            `ALS_MASK:   n.hrdata = {30'h0, q.mask};
            `ALS_INTCLR: n.hrdata = {31'h0, q.int_act};
            default:     n.hrdata = 32'h0;
         endcase
         if (haddr[7:0] == `ALS_STATUS) begin
            n.stat = 2'b00; // read clears
         end
      end

      // ahb-lite data phase: register writes
      clr_wr = 1'b0;
      if (q.a_wr) begin
         unique case (q.a_addr)
            `ALS_CTRL: begin
               n.en    = hwdata[`ALS_CTRL_EN];
               n.inten = hwdata[`ALS_CTRL_INTEN];
               n.alert = hwdata[`ALS_CTRL_ALERT];
               n.gain  = hwdata[`ALS_CTRL_GAIN +: 2];
            end
            `ALS_TIMING: n.icnt   = hwdata[7:0];
            `ALS_THR_LO: n.thr_lo = hwdata[15:0];
            `ALS_THR_HI: n.thr_hi = hwdata[15:0];
            `ALS_PERS:   n.pers   = hwdata[3:0];
            `ALS_MASK:   n.mask   = hwdata[1:0];
            `ALS_INTCLR: clr_wr   = hwdata[0];
            default: ;
         endcase
      end

      // pin release: host clear in level style, alert response in alert style
      if ((clr_wr && !q.alert) || (ara_done && q.alert)) begin
         n.int_act = 1'b0;
      end

      // sticky events, a new event wins over a clear
      if (conv_end) begin
         n.stat[`ALS_ST_DONE] = 1'b1;
      end
      if (thr_hit) begin
         n.stat[`ALS_ST_THR] = 1'b1;
      end
      if (thr_hit && q.inten) begin
         n.int_act = 1'b1;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q        <= '0;
         q.scl_m  <= 1'b1;
         q.scl_s  <= 1'b1;
         q.sda_m  <= 1'b1;
         q.sda_s  <= 1'b1;
         q.en     <= CTRL_RST[`ALS_CTRL_EN];
         q.inten  <= CTRL_RST[`ALS_CTRL_INTEN];
         q.alert  <= CTRL_RST[`ALS_CTRL_ALERT];
         q.icnt   <= `ALS_TIMING_RST;
         q.thr_lo <= `ALS_THR_LO_RST;
         q.thr_hi <= `ALS_THR_HI_RST;
         q.pers   <= `ALS_PERS_RST;
      end else begin
         q <= n;
      end
   end

   // serial link slave on the synchronised pins
   als_i2c_slave u_link (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .scl_s     (q.scl_s),
      .sda_s     (q.sda_s),
      .rd_data   ({q.res1, q.res0}),
      .alert_act (q.int_act & q.alert),
      .sda_oe_n  (sda_oe_n),
      .ara_done  (ara_done)
   );

   // bus answers and pins
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign irq       = |(q.stat & q.mask);
   assign sda_o     = 1'b0;
   assign int_o     = 1'b0;
   assign int_oe_n  = ~q.int_act; // open drain, low when asserted
   assign gain_o    = q.gain;

   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_idle_clear;
      !q.en |=> q.acc0 == 16'h0 && q.acc1 == 16'h0 && q.cyc == 8'h00;
   endproperty
   a_idle_clear: assert property (p_idle_clear) else $error("idle accumulators");

   property p_load;
      conv_end |=> q.res0 >= $past(q.acc0) && q.res1 >= $past(q.acc1);
   endproperty
   a_load: assert property (p_load) else $error("result load lost");

   property p_hold;
      !conv_end |=> $stable(q.res0) && $stable(q.res1);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed");

   sequence s_end;
      conv_end;
   endsequence
   property p_restart;
      s_end |=> q.acc0 == 16'h0 && q.acc1 == 16'h0 && q.tick == 19'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");

   property p_window;
      thr_hit |-> conv_end && outside(n.res0, q.thr_lo, q.thr_hi);
   endproperty
   a_window: assert property (p_window) else $error("hit inside window");

   property p_persist;
      conv_end && !out_win |-> !thr_hit ##1 q.oor == 4'h0;
   endproperty
   a_persist: assert property (p_persist) else $error("persistence");

   property p_level_hold;
      q.int_act && !q.alert && !clr_wr |=> q.int_act;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level drop");

   property p_alert_rel;
      ara_done && q.alert && !thr_hit |=> !q.int_act && int_oe_n;
   endproperty
   a_alert_rel: assert property (p_alert_rel) else $error("alert kept");

   property p_pin_fall;
      $fell(int_oe_n) |-> $past(thr_hit) && int_o == 1'b0;
   endproperty
   a_pin_fall: assert property (p_pin_fall) else $error("pin without hit");

   sequence s_hit_armed;
      thr_hit && q.inten;
   endsequence
   property p_int_set;
      s_hit_armed |=> !int_oe_n && q.int_act;
   endproperty
   a_int_set: assert property (p_int_set) else $error("hit left pin released");

   sequence s_host_clear;
      clr_wr && !q.alert && !thr_hit;
   endsequence
   property p_level_clear;
      s_host_clear |=> int_oe_n;
   endproperty
   a_level_clear: assert property (p_level_clear) else $error("clear ignored");

   property p_alert_keep;
      q.int_act && q.alert && !ara_done |=> q.int_act;
   endproperty
   a_alert_keep: assert property (p_alert_keep) else $error("alert dropped early");

   property p_cycle_len;
      conv_end |-> q.tick == TICK_LAST && q.cyc >= cyc_last;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("window length");

   property p_tick_step;
      q.en && q.tick != TICK_LAST |=> q.tick == $past(q.tick) + 19'h1;
   endproperty
   a_tick_step: assert property (p_tick_step) else $error("tick skipped");

   property p_count_step;
      q.en && !conv_end |=> q.acc0 - $past(q.acc0) <= 16'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count jump");

   property p_thr_flag;
      thr_hit |=> q.stat[`ALS_ST_THR];
   endproperty
   a_thr_flag: assert property (p_thr_flag) else $error("hit flag lost");

   property p_no_early;
      conv_end && out_win && q.oor != 4'hf && q.oor + 4'h1 < pers_eff |-> !thr_hit;
   endproperty
   a_no_early: assert property (p_no_early) else $error("hit before persistence");
endmodule
`default_nettype wire

// >>> sim/als_tb_host.sv
// host model: i2c master on the light sensor link
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/1ps
`default_nettype none
module als_tb_host (
   output var logic scl_o,
   output var logic sda_o,
   input  wire logic sda_i
);
   // idle: both lines released, link clock stands high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // start: data falls while the clock is high
   task automatic start();
      sda_o = 1'b1;
      #31.25 scl_o = 1'b1;
      #62.5 sda_o = 1'b0;
      #62.5 scl_o = 1'b0;
      #31.25;
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      sda_o = 1'b0;
      #31.25 scl_o = 1'b1;
      #62.5 sda_o = 1'b1;
      #62.5;
   endtask
   // one bit: set in low phase, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      #31.25 scl_o = 1'b1;
      #62.5 r = sda_i;
      scl_o = 1'b0;
      #31.25;
   endtask
   // byte out msb first, returns the ack level
   task automatic put_byte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, nack);
   endtask
   // byte in msb first, then ack or nack
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench: ahb-lite master, i2c host, converter pulses
// assumes als_readout and als_tb_host are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "als_defines.svh"
module tb;
   typedef struct packed {logic [31:0] m; logic [31:0] v;} als_exp_t;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, gain_o;
   logic [2:0]  hsize;
   logic        scl_h, sda_h, sda_o, sda_oe_n, int_o, int_oe_n, ch0_p, ch1_p, rd_ph;
   logic [3:0]  div0, div1;
   int          fails, check_count, cyc_n, seed;
   als_exp_t    exp_q[$];
   als_exp_t    e;
   wire logic   sda_w = sda_h & (sda_oe_n | sda_o);
   wire logic   int_w = int_oe_n | int_o;
   localparam logic [7:0]  RA[8] = '{`ALS_CTRL, `ALS_TIMING, `ALS_THR_LO, `ALS_THR_HI,
                                     `ALS_PERS, `ALS_MASK, `ALS_DATA, 8'h24};
   localparam logic [31:0] RM[8] = '{32'h37, 32'hff, 32'hffff, 32'hffff, 32'hf, 32'h3, '1, '1};
   localparam logic [31:0] RV[8] = '{`ALS_CTRL_RST, `ALS_TIMING_RST, `ALS_THR_LO_RST,
                                     `ALS_THR_HI_RST, `ALS_PERS_RST, 32'h0, 32'h0, 32'h0};
   localparam logic [7:0]  EB[4] = '{8'h05, 8'h00, 8'h02, 8'h00};

   als_readout #(.INTEG_CYC_CLKS(20)) i_als_readout (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .scl_i(scl_h),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .int_i(int_w), .int_o(int_o),
      .int_oe_n(int_oe_n), .ch0_pulse_i(ch0_p), .ch1_pulse_i(ch1_p), .gain_o(gain_o));
   als_tb_host i_als_tb_host (.scl_o(scl_h), .sda_o(sda_h), .sda_i(sda_w));

   // 100 mhz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // converter pulses: ch0 every 4 clocks, ch1 every 10, so 5 and 2 per window
   always @(posedge hclk) begin
      div0 <= div0 + 4'd1;
      div1 <= (div1 == 4'd4) ? 4'd0 : div1 + 4'd1;
      if (div0[0]) ch0_p <= ~ch0_p;
      if (div1 == 4'd4) ch1_p <= ~ch1_p;
   end
   // hang guard
   always @(posedge hclk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   // read monitor: oldest note is compared when a read data phase ends
   always @(posedge hclk) begin
      if (rd_ph && hreadyout && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e.m != 32'h0) check(hrdata & e.m, e.v);
      end
      rd_ph = hsel && htrans[1] && !hwrite && hreadyout;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // single ahb-lite transfer, reads note their expectation first
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] m, input logic [31:0] v, output logic [31:0] rd);
      @(posedge hclk);
      if (!w) exp_q.push_back('{m, v});
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, 32'h0, 32'h0, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, m, v, x);
   endtask
   // polls status until a conversion has ended; the read clears it
   task automatic wait_conv(output logic [31:0] st);
      st = 32'h0;
      for (int n = 0; n < 400 && st[`ALS_ST_DONE] !== 1'b1; n++)
         ahb(1'b0, `ALS_STATUS, 32'h0, 32'h0, 32'h0, st);
      check({31'h0, st[`ALS_ST_DONE]}, 32'h1);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      logic [31:0] st, r;
      logic [7:0]  b;
      logic        nk;
      {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      {ch0_p, ch1_p, div0, div1, rd_ph, fails, check_count, cyc_n} = '0;
      seed = 32'hd2f2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      r = $random(seed);
      wr(8'h24, r);
      wr(`ALS_DATA, r);
      for (int i = 0; i < 8; i++) rdc(RA[i], RM[i], RV[i]);
      check({hresp, hreadyout, int_oe_n, irq}, 4'b0110);
      $display("test reset done");
      wr(`ALS_THR_LO, r);
      rdc(`ALS_THR_LO, 32'hffff, {16'h0, r[15:0]});
      wr(`ALS_THR_LO, 32'h0);
      wr(`ALS_CTRL, {26'h0, r[17:16], 4'h3});
      repeat (2) @(posedge hclk);
      check(gain_o, r[17:16]);
      wr(`ALS_TIMING, 32'h1);
      rdc(`ALS_TIMING, 32'hff, 32'h1);
      wait_conv(st);
      wait_conv(st);
      rdc(`ALS_DATA, '1, 32'h0002_0005);
      $display("test results done");
      i_als_tb_host.start();
      i_als_tb_host.put_byte(8'h56, nk);
      i_als_tb_host.stop();
      check(nk, 1'b1);
      i_als_tb_host.start();
      i_als_tb_host.put_byte({`ALS_I2C_ADDR, 1'b0}, nk);
      i_als_tb_host.put_byte(8'h02, nk);
      i_als_tb_host.stop();
      i_als_tb_host.start();
      i_als_tb_host.put_byte({`ALS_I2C_ADDR, 1'b1}, nk);
      for (int i = 0; i < 4; i++) begin
         i_als_tb_host.get_byte(i == 3, b);
         check(b, EB[(i + 2) % 4]);
      end
      i_als_tb_host.stop();
      $display("test link done");
      wr(`ALS_PERS, 32'h3);
      wait_conv(st);
      wait_conv(st);
      wr(`ALS_THR_HI, 32'h3);
      wait_conv(st);
      wait_conv(st);
      check(st[`ALS_ST_THR], 1'b0);
      wait_conv(st);
      check(st[`ALS_ST_THR], 1'b1);
      repeat (2) @(posedge hclk);
      check({int_w, int_oe_n, irq}, 3'b000);
      wr(`ALS_MASK, 32'h2);
      repeat (25) @(posedge hclk);
      check(irq, 1'b1);
      wr(`ALS_THR_HI, 32'hffff);
      wait_conv(st);
      wait_conv(st);
      repeat (25) @(posedge hclk);
      check({int_oe_n, irq}, 2'b00);
      wr(`ALS_INTCLR, 32'h1);
      repeat (2) @(posedge hclk);
      check({int_w, int_oe_n}, 2'b11);
      $display("test level done");
      wr(`ALS_CTRL, 32'h07);
      wr(`ALS_PERS, 32'h1);
      wr(`ALS_THR_LO, 32'h6);
      wait_conv(st);
      wait_conv(st);
      check(st[`ALS_ST_THR], 1'b1);
      wr(`ALS_THR_LO, 32'h0);
      wr(`ALS_INTCLR, 32'h1);
      repeat (2) @(posedge hclk);
      check(int_oe_n, 1'b0);
      i_als_tb_host.start();
      i_als_tb_host.put_byte({`ALS_ARA_ADDR, 1'b1}, nk);
      i_als_tb_host.get_byte(1'b1, b);
      i_als_tb_host.stop();
      check({nk, b}, {1'b0, `ALS_I2C_ADDR, 1'b0});
      repeat (4) @(posedge hclk);
      check(int_oe_n, 1'b1);
      $display("test alert done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
